/* File: hdl/dac_code_load_command_decoder.sv */
// Command decoder for a four-channel 12-bit DAC with a Wishbone register port
//
// Summary of operation
// - Bit 23 reserved zero, bit 22 multibyte, bits 21-19 opcode.
// - Bits 18-16 pick channel A-D; bit 18 set picks all four.
// - Code write updates holding only; output moves only if transparent.
// - Load copies holding into output of selected channels, ignores data.
// - Load to all channels updates outputs, leaves holding untouched.
// - Write-and-update-all writes selected holding, then loads every output with changed holding.
// - Write-and-update-all skips outputs whose holding is unchanged since load.
// - Write-and-update-selected writes and loads only selected channels.
// - Write-and-update-selected skips selected channels with unchanged holding.
// - Multibyte flag gives same register effect as standard form.
// - Holding and output codes reset to zero.
// - Transparent channel passes holding straight to output.
`timescale 1ns/1ns
module dac_code_load_command_decoder
    import dac_cmd_pkg::*;
#(
    parameter int ADR_W = 8
)
(
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [ADR_W-1:0]         wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    output logic [31:0]                   wb_dat_o,
    output logic                          wb_ack_o,
    output logic [NUM_CH-1:0][CODE_W-1:0] dac_code_o
);
    import dac_cmd_pkg::*;

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic        req;
    logic        wr_stb;
    logic [7:0]  adr;

    assign req    = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign wr_stb = req && wb_we_i;
    assign adr    = 8'(wb_adr_i);

    logic        word_wr;
    logic        byte_wr;
    logic        ctrl_wr0;
    logic        ctrl_wr1;

    // A whole command word must be written in one access or it is not taken
    assign word_wr  = wr_stb && (adr == OFS_CMD_WORD) && (wb_sel_i[2:0] == 3'h7);
    assign byte_wr  = wr_stb && (adr == OFS_CMD_BYTE) && wb_sel_i[0];
    assign ctrl_wr0 = wr_stb && (adr == OFS_CTRL) && wb_sel_i[0];
    assign ctrl_wr1 = wr_stb && (adr == OFS_CTRL) && wb_sel_i[1];

    // ------------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0] transp_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            transp_r <= TRANSP_RESET;
        end else if (ctrl_wr0) begin
            transp_r <= wb_dat_i[CTRL_TRANSP_LSB +: NUM_CH];
        end
    end

    // ------------------------------------------------------------------
    // Byte stream assembly
    // ------------------------------------------------------------------
    logic        asm_valid;
    frame_t      asm_frame;
    logic [2:0]  asm_phase;

    frame_byte_assembler u_asm (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .byte_valid_i  (byte_wr),
        .byte_i        (wb_dat_i[BYTE_W-1:0]),
        .abort_i       (ctrl_wr1 && wb_dat_i[CTRL_ABORT_BIT]),
        .frame_valid_o (asm_valid),
        .frame_o       (asm_frame),
        .phase_o       (asm_phase)
    );

    // ------------------------------------------------------------------
    // Frame decode
    // ------------------------------------------------------------------
    logic   fvalid;
    frame_t frame;
    logic   supported;
    logic   bad_r;
    logic   multi_r;

    // Bus accesses are one at a time, so the two sources never collide
    always_comb begin
        fvalid = word_wr || asm_valid;
        frame  = word_wr ? frame_t'(wb_dat_i[FRAME_W-1:0]) : asm_frame;
    end

    // The multibyte flag is only recorded: effect is the same either way
    assign supported = !frame.reserved && !frame.opcode[2];

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            multi_r <= 1'b0;
        end else if (fvalid && supported) begin
            multi_r <= frame.multibyte;
        end
    end

    // A rejected frame that lands with the clear still leaves the flag set
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            bad_r <= 1'b0;
        end else if (fvalid && !supported) begin
            bad_r <= 1'b1;
        end else if (ctrl_wr1 && wb_dat_i[CTRL_CLR_BAD_BIT]) begin
            bad_r <= 1'b0;
        end
    end

    ch_ctl_t [NUM_CH-1:0] ctl;
    logic [NUM_CH-1:0]    mask;
    logic [CODE_W-1:0]    new_code;

    always_comb begin
        mask     = chan_mask(frame);
        new_code = {frame.code_hi, frame.code_lo};
        for (int i = 0; i < NUM_CH; i++) begin
            ctl[i].code         = new_code;
            ctl[i].wr           = 1'b0;
            ctl[i].load         = 1'b0;
            ctl[i].load_changed = 1'b0;
            if (fvalid && supported) begin
                unique case (frame.opcode)
                    OP_CODE_WRITE: begin
                        ctl[i].wr = mask[i];
                    end
                    OP_LOAD_SELECTED: begin
                        ctl[i].load = mask[i];
                    end
                    OP_WRITE_UPD_ALL: begin
                        ctl[i].wr           = mask[i];
                        ctl[i].load_changed = 1'b1;
                    end
                    OP_WRITE_UPD_SEL: begin
                        ctl[i].wr           = mask[i];
                        ctl[i].load_changed = mask[i];
                    end
                    default: begin
                        ctl[i].wr = 1'b0;
                    end
                endcase
            end
        end
    end

    // ------------------------------------------------------------------
    // Channel registers
    // ------------------------------------------------------------------
    logic [NUM_CH-1:0][CODE_W-1:0] hold;
    logic [NUM_CH-1:0]             dirty;

    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        dac_channel_regs u_ch (
            .clk_i         (clk_i),
            .rst_i         (rst_i),
            .ctl_i         (ctl[g]),
            .transparent_i (transp_r[g]),
            .hold_o        (hold[g]),
            .out_o         (dac_code_o[g]),
            .dirty_o       (dirty[g])
        );
    end

    // ------------------------------------------------------------------
    // Read data and acknowledge
    // ------------------------------------------------------------------
    logic [31:0] rd_data;

    always_comb begin
        rd_data = 32'h0000_0000;
        if (adr == OFS_CTRL) begin
            rd_data[CTRL_TRANSP_LSB +: NUM_CH] = transp_r;
        end else if (adr == OFS_STATUS) begin
            rd_data[STAT_PHASE_LSB +: 3]      = asm_phase;
            rd_data[STAT_BAD_BIT]             = bad_r;
            rd_data[STAT_MULTI_BIT]           = multi_r;
            rd_data[STAT_DIRTY_LSB +: NUM_CH] = dirty;
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                if (adr == OFS_HOLD0 + 8'(4 * i)) begin
                    rd_data[CODE_W-1:0] = hold[i];
                end
                if (adr == OFS_OUT0 + 8'(4 * i)) begin
                    rd_data[CODE_W-1:0] = dac_code_o[i];
                end
            end
        end
    end

    // Every access, mapped or not, is answered one cycle later
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end else begin
            wb_ack_o <= req;
            if (req && !wb_we_i) begin
                wb_dat_o <= rd_data;
            end
        end
    end

endmodule : dac_code_load_command_decoder

/* File: hdl/dac_cmd_pkg.sv */
// Shared constants and types for the four-channel code-load command decoder
package dac_cmd_pkg;

    // ------------------------------------------------------------------
    // Sizes
    // ------------------------------------------------------------------
    localparam int NUM_CH      = 4;
    localparam int CODE_W      = 12;
    localparam int FRAME_W     = 24;
    localparam int BYTE_W      = 8;

    // ------------------------------------------------------------------
    // Register byte offsets on the Wishbone bus
    // ------------------------------------------------------------------
    localparam logic [7:0] OFS_CMD_WORD = 8'h00;
    localparam logic [7:0] OFS_CMD_BYTE = 8'h04;
    localparam logic [7:0] OFS_CTRL     = 8'h08;
    localparam logic [7:0] OFS_STATUS   = 8'h0C;
    localparam logic [7:0] OFS_HOLD0    = 8'h10;
    localparam logic [7:0] OFS_OUT0     = 8'h20;

    // ------------------------------------------------------------------
    // Field positions
    // ------------------------------------------------------------------
    localparam int CTRL_TRANSP_LSB   = 0;
    localparam int CTRL_ABORT_BIT    = 8;
    localparam int CTRL_CLR_BAD_BIT  = 9;
    localparam int STAT_PHASE_LSB    = 0;
    localparam int STAT_BAD_BIT      = 4;
    localparam int STAT_MULTI_BIT    = 5;
    localparam int STAT_DIRTY_LSB    = 8;

    // ------------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------------
    localparam logic [CODE_W-1:0] CODE_RESET   = 12'h000;
    localparam logic [3:0]        TRANSP_RESET = 4'h0;

    // ------------------------------------------------------------------
    // Command encodings
    // ------------------------------------------------------------------
    localparam logic [2:0] OP_CODE_WRITE    = 3'h0;
    localparam logic [2:0] OP_LOAD_SELECTED = 3'h1;
    localparam logic [2:0] OP_WRITE_UPD_ALL = 3'h2;
    localparam logic [2:0] OP_WRITE_UPD_SEL = 3'h3;

    // Command frame as it arrives, most significant bit first
    typedef struct packed {
        logic       reserved;
        logic       multibyte;
        logic [2:0] opcode;
        logic       channel_sel_bit2;
        logic       channel_sel_bit1;
        logic       channel_sel_bit0;
        logic [7:0] code_hi;
        logic [3:0] code_lo;
        logic [3:0] dont_care;
    } frame_t;

    // Per-channel action produced by the decoder
    typedef struct packed {
        logic              wr;
        logic              load;
        logic              load_changed;
        logic [CODE_W-1:0] code;
    } ch_ctl_t;

    function automatic logic [NUM_CH-1:0] chan_mask(input frame_t f);
        logic [NUM_CH-1:0] m;
        m = 4'h0;
        if (f.channel_sel_bit2) begin
            m = 4'hF;
        end else begin
            m[{f.channel_sel_bit1, f.channel_sel_bit0}] = 1'b1;
        end
        return m;
    endfunction : chan_mask

endpackage : dac_cmd_pkg

/* File: hdl/frame_byte_assembler.sv */
// Collects command, high and low bytes into one 24-bit command frame
`timescale 1ns/1ns
module frame_byte_assembler
    import dac_cmd_pkg::*;
(
    input  wire logic               clk_i,
    input  wire logic               rst_i,
    input  wire logic               byte_valid_i,
    input  wire logic [BYTE_W-1:0]  byte_i,
    input  wire logic               abort_i,
    output logic                    frame_valid_o,
    output dac_cmd_pkg::frame_t     frame_o,
    output logic [2:0]              phase_o
);
    import dac_cmd_pkg::*;

    typedef enum logic [2:0] {
        ST_CMD = 3'b001,
        ST_HI  = 3'b010,
        ST_LO  = 3'b100
    } phase_t;

    phase_t                  state_r;
    logic [2*BYTE_W-1:0]     head_r;

    assign phase_o = state_r;

    // Abort drops a partial frame so a new one starts on the command byte
    always_ff @(posedge clk_i) begin
        if (rst_i || abort_i) begin
            state_r <= ST_CMD;
        end else if (byte_valid_i) begin
            unique case (state_r)
                ST_CMD: state_r <= ST_HI;
                ST_HI:  state_r <= ST_LO;
                ST_LO:  state_r <= ST_CMD;
                default: state_r <= ST_CMD;
            endcase
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            head_r <= 16'h0000;
        end else if (byte_valid_i && !abort_i) begin
            head_r <= {head_r[BYTE_W-1:0], byte_i};
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            frame_valid_o <= 1'b0;
            frame_o       <= '0;
        end else begin
            frame_valid_o <= byte_valid_i && !abort_i && (state_r == ST_LO);
            if (byte_valid_i && !abort_i && (state_r == ST_LO)) begin
                frame_o <= frame_t'({head_r, byte_i});
            end
        end
    end

endmodule : frame_byte_assembler

/* File: hdl/dac_channel_regs.sv */
// Holding and output code pair of one channel with change tracking
`timescale 1ns/1ns
module dac_channel_regs
    import dac_cmd_pkg::*;
(
    input  wire logic                 clk_i,
    input  wire logic                 rst_i,
    input  dac_cmd_pkg::ch_ctl_t      ctl_i,
    input  wire logic                 transparent_i,
    output logic [CODE_W-1:0]         hold_o,
    output logic [CODE_W-1:0]         out_o,
    output logic                      dirty_o
);
    import dac_cmd_pkg::*;

    logic [CODE_W-1:0] hold_nxt;
    logic              changed;

    always_comb begin
        hold_nxt = ctl_i.wr ? ctl_i.code : hold_o;
        changed  = dirty_o | (ctl_i.wr && (ctl_i.code != hold_o));
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            hold_o <= CODE_RESET;
        end else begin
            hold_o <= hold_nxt;
        end
    end

    // Output only moves on a load, or follows holding while transparent
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            out_o   <= CODE_RESET;
            dirty_o <= 1'b0;
        end else if (transparent_i || ctl_i.load) begin
            out_o   <= hold_nxt;
            dirty_o <= 1'b0;
        end else if (ctl_i.load_changed && changed) begin
            out_o   <= hold_nxt;
            dirty_o <= 1'b0;
        end else begin
            dirty_o <= changed;
        end
    end

endmodule : dac_channel_regs

/* File: testbench/dac_cmd_checker.sv */
// Concurrent checks on the command decoder's bus and code ports
`timescale 1ns/1ns
module dac_cmd_checker
    import dac_cmd_pkg::*;
#(
    parameter int ADR_W = 8
)
(
    input  wire logic                     clk_i,
    input  wire logic                     rst_i,
    input  wire logic                     wb_cyc_i,
    input  wire logic                     wb_stb_i,
    input  wire logic                     wb_we_i,
    input  wire logic [ADR_W-1:0]         wb_adr_i,
    input  wire logic [3:0]               wb_sel_i,
    input  wire logic [31:0]              wb_dat_i,
    input  wire logic [31:0]              wb_dat_o,
    input  wire logic                     wb_ack_o,
    input  wire logic [NUM_CH-1:0][CODE_W-1:0] dac_code_o
);
    import dac_cmd_pkg::*;
    // ------------------------------------------------------------------
    // Helper logic
    // ------------------------------------------------------------------
    logic       take;
    logic       cmdw;
    frame_t     fr;
    frame_t     frm_r;
    logic [3:0] transp_r;
    assign take = wb_cyc_i && wb_stb_i && !wb_ack_o;
    assign cmdw = take && wb_we_i && wb_adr_i == '0 && wb_sel_i[2:0] == 3'h7;
    assign fr   = frame_t'(wb_dat_i[23:0]);
    always_ff @(posedge clk_i) begin
        if (take) begin
            frm_r <= fr;
        end
    end
    // Mirror of the latch-mode bits so transparency can be allowed for
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            transp_r <= 4'h0;
        end else if (take && wb_we_i && wb_adr_i == ADR_W'(8'h08) && wb_sel_i[0]) begin
            transp_r <= wb_dat_i[3:0];
        end
    end
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    property p_ack_pulse;
        take |=> wb_ack_o ##1 !wb_ack_o;
    endproperty
    a_ack_pulse: assert property (p_ack_pulse) else $error("ack not one pulse after request");
    property p_reset_zero;
        $fell(rst_i) |-> dac_code_o == '0 && !wb_ack_o;
    endproperty
    a_reset_zero: assert property (p_reset_zero) else $error("codes not zero after reset");
    property p_bad_frame;
        cmdw && (fr.reserved || fr.opcode[2]) |=> $stable(dac_code_o);
    endproperty
    a_bad_frame: assert property (p_bad_frame) else $error("bad frame moved an output");
    property p_code_hold;
        cmdw && !fr.reserved && fr.opcode == OP_CODE_WRITE && transp_r == 4'h0
            |=> $stable(dac_code_o);
    endproperty
    a_code_hold: assert property (p_code_hold) else $error("code write moved an output");
    property p_sel_load;
        cmdw && !fr.reserved && fr.opcode == OP_WRITE_UPD_SEL && !fr.channel_sel_bit2
            |=> dac_code_o[{frm_r.channel_sel_bit1, frm_r.channel_sel_bit0}]
                == {frm_r.code_hi, frm_r.code_lo};
    endproperty
    a_sel_load: assert property (p_sel_load) else $error("selected output not loaded");
    property p_all_load;
        cmdw && !fr.reserved && fr.opcode == OP_WRITE_UPD_SEL && fr.channel_sel_bit2
            |=> dac_code_o == {4{frm_r.code_hi, frm_r.code_lo}};
    endproperty
    a_all_load: assert property (p_all_load) else $error("all-channel load wrong");
    property p_wua;
        cmdw && !fr.reserved && fr.opcode == OP_WRITE_UPD_ALL && !fr.channel_sel_bit2
            |=> dac_code_o[{frm_r.channel_sel_bit1, frm_r.channel_sel_bit0}]
                == {frm_r.code_hi, frm_r.code_lo};
    endproperty
    a_wua: assert property (p_wua) else $error("write-update-all output wrong");
    property p_transp;
        cmdw && !fr.reserved && fr.opcode == OP_CODE_WRITE && !fr.channel_sel_bit2
            && transp_r[{fr.channel_sel_bit1, fr.channel_sel_bit0}]
            |-> ##[1:2] dac_code_o[{frm_r.channel_sel_bit1, frm_r.channel_sel_bit0}]
                == {frm_r.code_hi, frm_r.code_lo};
    endproperty
    a_transp: assert property (p_transp) else $error("transparent output not following");
endmodule : dac_cmd_checker

bind dac_code_load_command_decoder dac_cmd_checker #(.ADR_W(ADR_W)) u_dac_cmd_checker (
    .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i),
    .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .dac_code_o(dac_code_o));

/* File: testbench/wb_host_model.sv */
// Wishbone host model standing in for the bus master side
`timescale 1ns/1ns
module wb_host_model (
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] rdat_i,
    output logic             cyc_o,
    output logic             stb_o,
    output logic             we_o,
    output logic [7:0]       adr_o,
    output logic [3:0]       sel_o,
    output logic [31:0]      dat_o
);
    initial begin
        cyc_o = 1'b0;
        stb_o = 1'b0;
        we_o  = 1'b0;
        adr_o = 8'h00;
        sel_o = 4'h0;
        dat_o = 32'h0;
    end
    // One classic cycle; held until ack, then one idle cycle at least
    task automatic xfer(input logic we, input logic [7:0] a, input logic [3:0] s,
                        input logic [31:0] d, output logic [31:0] q, output logic ok);
        int n;
        @(posedge clk_i);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o  <= we;
        adr_o <= a;
        sel_o <= s;
        dat_o <= d;
        ok = 1'b0;
        n  = 0;
        while (!ok && n < 50) begin
            @(posedge clk_i);
            n++;
            ok = (ack_i === 1'b1);
        end
        q = rdat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        we_o  <= 1'b0;
        // Released data is inverted so a stale value is never mistaken
        dat_o <= ~d;
        @(posedge clk_i);
    endtask : xfer
endmodule : wb_host_model

/* File: testbench/tb.sv */
// Self-checking bench for the four-channel code-load command decoder
`timescale 1ns/1ns
module tb;
    import dac_cmd_pkg::*;
    logic                     clk_i, rst_i, cyc, stb, we, ack;
    logic [7:0]               adr;
    logic [3:0]               sel;
    logic [31:0]              wdat, rdat;
    logic [NUM_CH-1:0][CODE_W-1:0] dac_code;
    int                       err_total, checks_done;

    dac_code_load_command_decoder #(.ADR_W(8)) u_dac_code_load_command_decoder (
        .clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .dac_code_o(dac_code));
    wb_host_model u_wb_host_model (
        .clk_i(clk_i), .ack_i(ack), .rdat_i(rdat), .cyc_o(cyc), .stb_o(stb),
        .we_o(we), .adr_o(adr), .sel_o(sel), .dat_o(wdat));

    initial begin
        clk_i = 1'b0;
        forever #2 clk_i = ~clk_i;
    end
    // ------------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------------
    task final_report;
        $display("checks %0d mismatches %0d", checks_done, err_total);
        if (err_total == 0 && checks_done > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : final_report
    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            err_total++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
        logic ok;
        u_wb_host_model.xfer(w, a, 4'hF, d, q, ok);
        if (!ok) begin
            err_total++;
            $display("Error bus ack expected 1 seen 0");
            final_report();
        end
    endtask : bus
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        bus(1'b1, a, d, q);
    endtask : wr
    task rd_chk(input string nm, input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] q;
        bus(1'b0, a, 32'h0, q);
        chk(nm, q, exp);
    endtask : rd_chk
    // Holding and output registers of one channel, plus its output port
    task ch_chk(input int ch, input logic [11:0] h, input logic [11:0] o);
        rd_chk("hold", OFS_HOLD0 + 8'(4 * ch), {20'h0, h});
        rd_chk("out", OFS_OUT0 + 8'(4 * ch), {20'h0, o});
        chk("dac_code", {20'h0, dac_code[ch]}, {20'h0, o});
    endtask : ch_chk
    // ------------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------------
    task t_reset;
        for (int c = 0; c < 4; c++) ch_chk(c, 12'h000, 12'h000);
        $display("test reset done");
    endtask : t_reset
    task t_code_load;
        for (int c = 0; c < 4; c++) begin
            wr(OFS_CMD_WORD, {8'h00, 8'(c), 12'hA50 + 12'(c), 4'hF});
            ch_chk(c, 12'hA50 + 12'(c), 12'h000);
        end
        wr(OFS_CMD_WORD, {8'h00, 8'h09, 16'hFFFF});
        ch_chk(1, 12'hA51, 12'hA51);
        ch_chk(0, 12'hA50, 12'h000);
        wr(OFS_CMD_WORD, {8'h00, 8'h0C, 16'h0000});
        for (int c = 0; c < 4; c++) ch_chk(c, 12'hA50 + 12'(c), 12'hA50 + 12'(c));
        $display("test code and load done");
    endtask : t_code_load
    task t_bytes_and_update_all;
        wr(OFS_CMD_BYTE, 32'h44);
        wr(OFS_CMD_BYTE, 32'h12);
        wr(OFS_CMD_BYTE, 32'h3F);
        for (int c = 0; c < 4; c++) ch_chk(c, 12'h123, 12'hA50 + 12'(c));
        rd_chk("status", OFS_STATUS, 32'h0000_0F21);
        wr(OFS_CMD_WORD, {8'h00, 8'h00, 16'h7770});
        wr(OFS_CMD_WORD, {8'h00, 8'h12, 16'h4560});
        ch_chk(0, 12'h777, 12'h777);
        ch_chk(1, 12'h123, 12'h123);
        ch_chk(2, 12'h456, 12'h456);
        ch_chk(3, 12'h123, 12'h123);
        rd_chk("status", OFS_STATUS, 32'h0000_0001);
        $display("test bytes and update all done");
    endtask : t_bytes_and_update_all
    task t_update_sel;
        wr(OFS_CMD_WORD, {8'h00, 8'h01, 16'hFFF0});
        wr(OFS_CMD_WORD, {8'h00, 8'h1B, 16'h89A0});
        ch_chk(1, 12'hFFF, 12'h123);
        ch_chk(3, 12'h89A, 12'h89A);
        wr(OFS_CMD_WORD, {8'h00, 8'h5C, 16'h3210});
        for (int c = 0; c < 4; c++) ch_chk(c, 12'h321, 12'h321);
        $display("test update selected done");
    endtask : t_update_sel
    task t_bad_and_transp;
        wr(OFS_CMD_WORD, {8'h00, 8'h81, 16'hEEE0});
        wr(OFS_CMD_WORD, {8'h00, 8'h20, 16'hEEE0});
        ch_chk(0, 12'h321, 12'h321);
        rd_chk("unmapped", 8'h40, 32'h0);
        rd_chk("status", OFS_STATUS, 32'h0000_0031);
        // A lone command byte is dropped by abort; the same write clears bad
        wr(OFS_CMD_BYTE, 32'h0000_0000);
        wr(OFS_CTRL, 32'h0000_0300);
        rd_chk("status", OFS_STATUS, 32'h0000_0021);
        wr(OFS_CTRL, 32'h1);
        wr(OFS_CMD_WORD, {8'h00, 8'h00, 16'h5A50});
        ch_chk(0, 12'h5A5, 12'h5A5);
        wr(OFS_CTRL, 32'h0);
        $display("test bad frame and transparency done");
    endtask : t_bad_and_transp
    // ------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------
    initial begin
        err_total = 0;
        checks_done = 0;
        rst_i = 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        t_code_load();
        t_bytes_and_update_all();
        t_update_sel();
        t_bad_and_transp();
        // Second reset in mid-run must clear everything again
        @(posedge clk_i);
        rst_i <= 1'b1;
        repeat (10) @(posedge clk_i);
        rst_i <= 1'b0;
        t_reset();
        final_report();
    end
endmodule : tb
